// file: include/krts_pkg.sv
// Purpose: Shared constants and types for the partner training status bank
// Assumes: Avalon-MM word-indexed register map, 32-bit data
// Notes:   Byte address is four times the word index
package krts_pkg;
    // Register word indices; not all multiples of four, so byte addr = 4*index
    localparam logic [11:0] IDX_COEF_EXCH   = 12'h4D4;
    localparam logic [11:0] IDX_TAP_READ    = 12'h4D5;
    localparam logic [11:0] IDX_TRAIN_CTRL  = 12'h4D7;
    localparam int ADDR_W                   = 14;
    localparam logic [13:0] ADDR_COEF_EXCH  = {IDX_COEF_EXCH, 2'b00};
    localparam logic [13:0] ADDR_TAP_READ   = {IDX_TAP_READ, 2'b00};
    localparam logic [13:0] ADDR_TRAIN_CTRL = {IDX_TRAIN_CTRL, 2'b00};
    // Field positions in the coefficient exchange word
    localparam int POS_REQ      = 16;
    localparam int POS_INIT     = 22;
    localparam int POS_PRESET   = 23;
    localparam int POS_REPORT   = 24;
    localparam int POS_RXDONE   = 30;
    // Field positions in the tap readback word
    localparam int POS_MAIN     = 0;
    localparam int POS_POST     = 8;
    localparam int POS_PRE      = 16;
    // Training control bit position and reset value
    localparam int POS_TRAIN_EN = 0;
    localparam logic RST_TRAIN_EN = 1'b1;
    // Tap widths and limits
    localparam int MAIN_W = 5;
    localparam int POST_W = 6;
    localparam int PRE_W  = 5;
    localparam logic [4:0] MAIN_INIT   = 5'h14;
    localparam logic [5:0] POST_INIT   = 6'h08;
    localparam logic [4:0] PRE_INIT    = 5'h02;
    localparam logic [4:0] MAIN_PRESET = 5'h1F;
    localparam logic [5:0] POST_PRESET = 6'h00;
    localparam logic [4:0] PRE_PRESET  = 5'h00;
    localparam logic [4:0] MAIN_MAX    = 5'h1F;
    localparam logic [5:0] POST_MAX    = 6'h3F;
    localparam logic [4:0] PRE_MAX     = 5'h1F;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // Coefficient request codes
    typedef enum logic [1:0] {
        KRTS_REQ_HOLD = 2'b00,
        KRTS_REQ_INC  = 2'b01,
        KRTS_REQ_DEC  = 2'b10,
        KRTS_REQ_RSVD = 2'b11
    } krts_req_e;

    // Coefficient status codes
    typedef enum logic [1:0] {
        KRTS_ST_NOTUPD = 2'b00,
        KRTS_ST_MIN    = 2'b01,
        KRTS_ST_UPD    = 2'b10,
        KRTS_ST_MAX    = 2'b11
    } krts_st_e;

    // One received training frame, control words already trimmed
    typedef struct packed {
        logic       init_req;
        logic       preset_req;
        logic [5:0] coef_req;
        logic       rx_done;
        logic [5:0] coef_report;
    } krts_frame_s;

    // Trained transmit taps
    typedef struct packed {
        logic [4:0] main_v;
        logic [5:0] post_v;
        logic [4:0] pre_v;
    } krts_taps_s;
endpackage

// file: hdl/krts_tap_step.sv
// Purpose: One transmit tap stepped by a coefficient request code
// Assumes: Steps saturate at zero and at the tap maximum
// Notes:   Used once per tap by the status bank
`timescale 1ns/1ps
`default_nettype none
module krts_tap_step #(
    parameter int W = 5
) (
    input  wire logic [W-1:0] cur,
    input  wire logic [1:0]   req,
    input  wire logic [W-1:0] max_v,
    output logic      [W-1:0] nxt,
    output logic      [1:0]   st
);
    // Decode the request; reserved code behaves as hold
    always_comb begin
        nxt = cur;
        st  = krts_pkg::KRTS_ST_NOTUPD;
        unique case (req)
            krts_pkg::KRTS_REQ_INC: begin
                if (cur == max_v) begin
                    st = krts_pkg::KRTS_ST_MAX;
                end else begin
                    nxt = cur + W'(1);
                    st  = (nxt == max_v) ? krts_pkg::KRTS_ST_MAX : krts_pkg::KRTS_ST_UPD;
                end
            end
            krts_pkg::KRTS_REQ_DEC: begin
                if (cur == '0) begin
                    st = krts_pkg::KRTS_ST_MIN;
                end else begin
                    nxt = cur - W'(1);
                    st  = (nxt == '0) ? krts_pkg::KRTS_ST_MIN : krts_pkg::KRTS_ST_UPD;
                end
            end
            krts_pkg::KRTS_REQ_HOLD: begin
                nxt = cur;
            end
            krts_pkg::KRTS_REQ_RSVD: begin
                nxt = cur;
            end
        endcase
    end
endmodule
`default_nettype wire

// file: hdl/krts_status_bank.sv
// Purpose: Partner training status registers with trained tap readback
// Assumes: Frames arrive as one-cycle valid strobes synchronous to CLK
// Notes:   Avalon-MM slave with waitrequest, one wait state per access
// Function
// - Show partner's first request word, six bits, from latest frame.
// - Request field read-only, writable by software when training disabled.
// - Request pair codes: 01 increment, 10 decrement, 00 hold, 11 reserved.
// - Upper pair is +1 request, middle pair 0, lowest pair -1.
// - Initialize request set puts transmit taps in INITIALIZE state.
// - Preset request set applies preset taps turning equalization off.
// - Show partner's second status word, six bits, read-only.
// - Status pair codes: 11 maximum, 01 minimum, 10 updated, 00 not.
// - Partner receiver-ready bit read-only, shows partner training complete.
// - Hold read-only main, post and pre tap copies, 5/6/5 bits.
// - Taps updated by coefficient logic from partner commands in training.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module krts_status_bank (
    input  wire logic                        CLK,
    input  wire logic                        RESET,
    input  wire logic                        CE,
    input  wire logic [krts_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic                        AVS_READ,
    input  wire logic                        AVS_WRITE,
    input  wire logic [31:0]                 AVS_WRITEDATA,
    input  wire logic [3:0]                  AVS_BYTEENABLE,
    output logic      [31:0]                 AVS_READDATA,
    output logic                             AVS_WAITREQUEST,
    input  wire logic                        FRAME_VALID,
    input  wire krts_pkg::krts_frame_s       FRAME,
    output krts_pkg::krts_taps_s             TX_TAPS,
    output logic      [5:0]                  TX_COEF_REPORT,
    output logic                             TRAINING_ENABLE
);
    // Bus handshake state
    typedef enum logic [1:0] {
        KRTS_BUS_IDLE = 2'b01,
        KRTS_BUS_ACK  = 2'b10
    } krts_bus_e;

    krts_bus_e                 bus_q, bus_d;
    logic                      ack;
    logic [31:0]               rdata_q, rdata_d;
    logic                      train_en_q, train_en_d;
    krts_pkg::krts_frame_s     frm_q, frm_d;
    krts_pkg::krts_taps_s      taps_q, taps_d;
    logic [5:0]                rep_q, rep_d;
    logic [4:0]                main_n, pre_n;
    logic [5:0]                post_n;
    logic [1:0]                main_st, post_st, pre_st;
    logic                      wr_exch, wr_ctrl;
    logic [31:0]               exch_word, taps_word;

    // Request waits one cycle so read data come from a flop
    assign ack             = (bus_q == KRTS_BUS_ACK);
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
    assign AVS_READDATA    = rdata_q;
    assign TX_TAPS         = taps_q;
    assign TX_COEF_REPORT  = rep_q;
    assign TRAINING_ENABLE = train_en_q;
    assign wr_exch = AVS_WRITE & ack & (AVS_ADDRESS == krts_pkg::ADDR_COEF_EXCH);
    assign wr_ctrl = AVS_WRITE & ack & (AVS_ADDRESS == krts_pkg::ADDR_TRAIN_CTRL);

    // Register images for reads
    always_comb begin
        exch_word = '0;
        exch_word[krts_pkg::POS_REQ +: 6]    = frm_q.coef_req;
        exch_word[krts_pkg::POS_INIT]        = frm_q.init_req;
        exch_word[krts_pkg::POS_PRESET]      = frm_q.preset_req;
        exch_word[krts_pkg::POS_REPORT +: 6] = frm_q.coef_report;
        exch_word[krts_pkg::POS_RXDONE]      = frm_q.rx_done;
        taps_word = '0;
        taps_word[krts_pkg::POS_MAIN +: krts_pkg::MAIN_W] = taps_q.main_v;
        taps_word[krts_pkg::POS_POST +: krts_pkg::POST_W] = taps_q.post_v;
        taps_word[krts_pkg::POS_PRE  +: krts_pkg::PRE_W]  = taps_q.pre_v;
    end

    // Bus slave: one wait state, then ack for a single cycle
    always_comb begin
        bus_d   = bus_q;
        rdata_d = rdata_q;
        unique case (bus_q)
            KRTS_BUS_IDLE: begin
                if (AVS_READ | AVS_WRITE) begin
                    bus_d = KRTS_BUS_ACK;
                end
                if (AVS_READ) begin
                    unique case (AVS_ADDRESS)
                        krts_pkg::ADDR_COEF_EXCH:  rdata_d = exch_word;
                        krts_pkg::ADDR_TAP_READ:   rdata_d = taps_word;
                        krts_pkg::ADDR_TRAIN_CTRL: rdata_d = {31'h0, train_en_q};
                        default:                   rdata_d = krts_pkg::RD_UNMAPPED;
                    endcase
                end
            end
            KRTS_BUS_ACK: begin
                bus_d = KRTS_BUS_IDLE;
            end
            default: begin
                bus_d = KRTS_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            bus_q   <= KRTS_BUS_IDLE;
            rdata_q <= 32'h0000_0000;
        end else if (CE) begin
            bus_q   <= bus_d;
            rdata_q <= rdata_d;
        end
    end

    // Training enable control, software owned
    always_comb begin
        train_en_d = train_en_q;
        if (wr_ctrl && AVS_BYTEENABLE[0]) begin
            train_en_d = AVS_WRITEDATA[krts_pkg::POS_TRAIN_EN];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            train_en_q <= krts_pkg::RST_TRAIN_EN;
        end else if (CE) begin
            train_en_q <= train_en_d;
        end
    end

    // Frame capture; frames win while training runs, software only when off
    always_comb begin
        frm_d = frm_q;
        if (FRAME_VALID && train_en_q) begin
            frm_d = FRAME;
        end else if (wr_exch && !train_en_q && AVS_BYTEENABLE[2]) begin
            frm_d.coef_req   = AVS_WRITEDATA[krts_pkg::POS_REQ +: 6];
            frm_d.init_req   = AVS_WRITEDATA[krts_pkg::POS_INIT];
            frm_d.preset_req = AVS_WRITEDATA[krts_pkg::POS_PRESET];
        end
    end

    // Tap steppers, +1 post, 0 main, -1 pre
    krts_tap_step #(.W(krts_pkg::POST_W)) u_post (
        .cur   (taps_q.post_v),
        .req   (frm_d.coef_req[5:4]),
        .max_v (krts_pkg::POST_MAX),
        .nxt   (post_n),
        .st    (post_st)
    );
    krts_tap_step #(.W(krts_pkg::MAIN_W)) u_main (
        .cur   (taps_q.main_v),
        .req   (frm_d.coef_req[3:2]),
        .max_v (krts_pkg::MAIN_MAX),
        .nxt   (main_n),
        .st    (main_st)
    );
    krts_tap_step #(.W(krts_pkg::PRE_W)) u_pre (
        .cur   (taps_q.pre_v),
        .req   (frm_d.coef_req[1:0]),
        .max_v (krts_pkg::PRE_MAX),
        .nxt   (pre_n),
        .st    (pre_st)
    );

    // Coefficient update; preset outranks initialize, which outranks steps
    always_comb begin
        taps_d = taps_q;
        rep_d  = rep_q;
        if (FRAME_VALID && train_en_q) begin
            if (FRAME.preset_req) begin
                taps_d.main_v = krts_pkg::MAIN_PRESET;
                taps_d.post_v = krts_pkg::POST_PRESET;
                taps_d.pre_v  = krts_pkg::PRE_PRESET;
                rep_d = {krts_pkg::KRTS_ST_UPD, krts_pkg::KRTS_ST_UPD, krts_pkg::KRTS_ST_UPD};
            end else if (FRAME.init_req) begin
                taps_d.main_v = krts_pkg::MAIN_INIT;
                taps_d.post_v = krts_pkg::POST_INIT;
                taps_d.pre_v  = krts_pkg::PRE_INIT;
                rep_d = {krts_pkg::KRTS_ST_UPD, krts_pkg::KRTS_ST_UPD, krts_pkg::KRTS_ST_UPD};
            end else begin
                taps_d.main_v = main_n;
                taps_d.post_v = post_n;
                taps_d.pre_v  = pre_n;
                rep_d = {post_st, main_st, pre_st};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            frm_q  <= '0;
            taps_q <= {krts_pkg::MAIN_INIT, krts_pkg::POST_INIT, krts_pkg::PRE_INIT};
            rep_q  <= 6'h00;
        end else if (CE) begin
            frm_q  <= frm_d;
            taps_q <= taps_d;
            rep_q  <= rep_d;
        end
    end

    // Checks
    sequence s_frame_in;
        CE && FRAME_VALID && train_en_q;
    endsequence

    chk_frame_capture: assert property (@(posedge CLK) disable iff (RESET)
        s_frame_in |=> frm_q == $past(FRAME))
        else $error("frame not captured");
    chk_fields_hold: assert property (@(posedge CLK) disable iff (RESET)
        (CE && !FRAME_VALID && !wr_exch) |=> $stable(frm_q))
        else $error("captured fields moved between frames");
    chk_req_ro: assert property (@(posedge CLK) disable iff (RESET)
        (CE && train_en_q && !FRAME_VALID) |=> $stable(frm_q.coef_req))
        else $error("request field written while training");
    chk_init_taps: assert property (@(posedge CLK) disable iff (RESET)
        (s_frame_in and FRAME.init_req && !FRAME.preset_req)
        |=> taps_q.main_v == krts_pkg::MAIN_INIT && taps_q.pre_v == krts_pkg::PRE_INIT)
        else $error("initialize not applied");
    chk_preset_taps: assert property (@(posedge CLK) disable iff (RESET)
        (s_frame_in and FRAME.preset_req) |=> taps_q.post_v == krts_pkg::POST_PRESET)
        else $error("preset not applied");
    chk_post_inc: assert property (@(posedge CLK) disable iff (RESET)
        (s_frame_in and !FRAME.init_req && !FRAME.preset_req
         && FRAME.coef_req[5:4] == 2'b01 && taps_q.post_v != krts_pkg::POST_MAX)
        |=> taps_q.post_v == $past(taps_q.post_v) + 6'h01)
        else $error("post tap increment wrong");
    chk_taps_idle: assert property (@(posedge CLK) disable iff (RESET)
        (CE && !(FRAME_VALID && train_en_q)) |=> $stable(taps_q))
        else $error("taps changed without frame");
    chk_bus_ack: assert property (@(posedge CLK) disable iff (RESET)
        (CE && (AVS_READ || AVS_WRITE) && bus_q == KRTS_BUS_IDLE) |=> !AVS_WAITREQUEST)
        else $error("bus answer late");
endmodule
`default_nettype wire

// file: verification/krts_partner_model.sv
// Purpose: Link partner model sending training frames
// Assumes: One frame in flight at a time
// Notes:   Frame lines toggle between frames so stale data shows
`timescale 1ns/1ps
`default_nettype none
module krts_partner_model (
    input  wire logic                  CLK,
    input  wire logic                  SEND,
    input  wire krts_pkg::krts_frame_s SEND_DATA,
    input  wire logic [1:0]            GAP,
    output logic                       FRAME_VALID,
    output krts_pkg::krts_frame_s      FRAME
);
    logic                  pend_q = 1'b0;
    logic [1:0]            cnt_q = 2'h0;
    krts_pkg::krts_frame_s hold_q;
    logic                  go;
    // Known levels before the first edge
    initial begin
        FRAME_VALID = 1'b0;
        FRAME = '0;
    end
    assign go = !SEND && pend_q && cnt_q == 2'h0;
    // Wait GAP cycles, so the partner answers promptly or slowly
    always @(posedge CLK) begin
        FRAME_VALID <= go;
        FRAME       <= go ? hold_q : ~FRAME;
        if (SEND) begin
            pend_q <= 1'b1;
            cnt_q  <= GAP;
            hold_q <= SEND_DATA;
        end else if (pend_q) begin
            pend_q <= cnt_q != 2'h0;
            cnt_q  <= cnt_q - 2'h1;
        end
    end
endmodule
`default_nettype wire

// file: verification/test_kr_link_partner_training_status.sv
// Purpose: Self-checking bench for the partner training status bank
// Assumes: CE tied high; every wait is bounded
// Notes:   Tap expectations come from a bench step model
`timescale 1ns/1ps
`default_nettype none
module test_kr_link_partner_training_status;
    logic                  CLK = 1'b0, RESET = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [13:0]           AVS_ADDRESS = 14'h0000;
    logic [31:0]           AVS_WRITEDATA = 32'h0, AVS_READDATA, rd_n, q;
    logic [3:0]            AVS_BYTEENABLE = 4'hF;
    logic                  AVS_WAITREQUEST, FRAME_VALID, TRAINING_ENABLE;
    logic                  send = 1'b0, wait_n = 1'b1, seen_n = 1'b0;
    logic [1:0]            gap = 2'h0;
    logic [5:0]            TX_COEF_REPORT, er = 6'h00;
    krts_pkg::krts_taps_s  TX_TAPS, et;
    krts_pkg::krts_frame_s FRAME, f, ef, sdata = '0;
    int                    miscompares = 0, n_compared = 0, seed = 32'h3F1EDEA5;

    krts_status_bank dut_u (
        .CLK(CLK), .RESET(RESET), .CE(1'b1),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .FRAME_VALID(FRAME_VALID), .FRAME(FRAME), .TX_TAPS(TX_TAPS),
        .TX_COEF_REPORT(TX_COEF_REPORT), .TRAINING_ENABLE(TRAINING_ENABLE)
    );
    krts_partner_model partner_u (
        .CLK(CLK), .SEND(send), .SEND_DATA(sdata), .GAP(gap),
        .FRAME_VALID(FRAME_VALID), .FRAME(FRAME)
    );

    // 20 MHz clock
    always #25 CLK = ~CLK;

    // Settled copies of outputs, used at the next rising edge to dodge races
    always @(negedge CLK) begin
        wait_n <= AVS_WAITREQUEST;
        seen_n <= FRAME_VALID;
        rd_n   <= AVS_READDATA;
    end

    task automatic report_and_stop();
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A used-up wait counts as a mismatch and ends the run
    task automatic bound(input int n);
        if (n >= 40) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        AVS_ADDRESS    <= a;
        AVS_WRITEDATA  <= d;
        AVS_BYTEENABLE <= be;
        AVS_READ       <= !wr;
        AVS_WRITE      <= wr;
        do begin
            @(posedge CLK);
            n++;
        end while (wait_n !== 1'b0 && n < 40);
        bound(n);
        q = rd_n;
        AVS_READ  <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLK);
    endtask

    // Hand a frame to the partner and wait until its strobe has passed
    task automatic frame(input krts_pkg::krts_frame_s fr);
        int n;
        n = 0;
        sdata <= fr;
        gap   <= 2'($random(seed));
        send  <= 1'b1;
        @(posedge CLK);
        send <= 1'b0;
        do begin
            @(posedge CLK);
            n++;
        end while (seen_n !== 1'b1 && n < 40);
        bound(n);
    endtask

    // Saturating step of one tap; reserved code holds
    function automatic logic [5:0] stp(input logic [5:0] c, input logic [1:0] r,
                                       input logic [5:0] mx);
        if (r == 2'b01 && c != mx) return c + 6'h01;
        if (r == 2'b10 && c != 6'h00) return c - 6'h01;
        return c;
    endfunction

    // Status pair for one tap step: 11 max, 01 min, 10 updated, 00 not updated
    function automatic logic [1:0] sst(input logic [5:0] c, input logic [1:0] r,
                                       input logic [5:0] mx);
        logic [5:0] n;
        n = stp(c, r, mx);
        if (r == 2'b01) return (n == mx) ? 2'b11 : 2'b10;
        if (r == 2'b10) return (n == 6'h00) ? 2'b01 : 2'b10;
        return 2'b00;
    endfunction

    // Local report after a frame; preset or initialize marks every tap updated
    function automatic logic [5:0] rpt(input krts_pkg::krts_taps_s t,
                                       input krts_pkg::krts_frame_s r);
        if (r.init_req || r.preset_req) return 6'h2A;
        return {sst(t.post_v, r.coef_req[5:4], krts_pkg::POST_MAX),
                sst({1'b0, t.main_v}, r.coef_req[3:2], {1'b0, krts_pkg::MAIN_MAX}),
                sst({1'b0, t.pre_v}, r.coef_req[1:0], {1'b0, krts_pkg::PRE_MAX})};
    endfunction

    // Preset beats initialize, which beats the per-tap steps
    function automatic krts_pkg::krts_taps_s nxt(input krts_pkg::krts_taps_s t,
                                                 input krts_pkg::krts_frame_s r);
        nxt.post_v = stp(t.post_v, r.coef_req[5:4], krts_pkg::POST_MAX);
        nxt.main_v = 5'(stp({1'b0, t.main_v}, r.coef_req[3:2], {1'b0, krts_pkg::MAIN_MAX}));
        nxt.pre_v  = 5'(stp({1'b0, t.pre_v}, r.coef_req[1:0], {1'b0, krts_pkg::PRE_MAX}));
        if (r.init_req)
            nxt = {krts_pkg::MAIN_INIT, krts_pkg::POST_INIT, krts_pkg::PRE_INIT};
        if (r.preset_req)
            nxt = {krts_pkg::MAIN_PRESET, krts_pkg::POST_PRESET, krts_pkg::PRE_PRESET};
    endfunction

    // Read back the exchange word, and optionally the taps
    task automatic chk(input logic taps);
        bus(1'b0, krts_pkg::ADDR_COEF_EXCH, 32'h0, 4'hF);
        check("exchange", {1'b0, ef.rx_done, ef.coef_report, ef.preset_req, ef.init_req,
              ef.coef_req, 16'h0000}, q & 32'h7FFF_0000);
        if (taps) begin
            bus(1'b0, krts_pkg::ADDR_TAP_READ, 32'h0, 4'hF);
            check("tap word", {11'h0, et.pre_v, 2'h0, et.post_v, 3'h0, et.main_v}, q);
            check("tap port", {16'h0, et}, {16'h0, TX_TAPS});
            check("report", {26'h0, er}, {26'h0, TX_COEF_REPORT});
        end
    endtask

    // Main sequence: reset values, frame traffic, then training disabled
    initial begin
        repeat (10) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        et = {krts_pkg::MAIN_INIT, krts_pkg::POST_INIT, krts_pkg::PRE_INIT};
        ef = '0;
        chk(1'b1);
        check("enable", 32'h1, {31'h0, TRAINING_ENABLE});
        bus(1'b0, 14'h0000, 32'h0, 4'hF);
        check("unmapped", krts_pkg::RD_UNMAPPED, q);
        // Corners first: preset, three increments with main held at max, initialize, fall to zero
        for (int i = 0; i < 100; i++) begin
            f = krts_pkg::krts_frame_s'(15'($random(seed)));
            if (i < 30) begin
                f.preset_req = i == 0;
                f.init_req   = i == 4;
                f.coef_req   = i < 4 ? 6'h15 : 6'h2A;
            end else if (i % 8 != 0) begin
                f.preset_req = 1'b0;
                f.init_req   = 1'b0;
            end
            frame(f);
            er = rpt(et, f);
            et = nxt(et, f);
            ef = f;
            chk(1'b1);
        end
        bus(1'b1, krts_pkg::ADDR_TRAIN_CTRL, 32'h0, 4'hF);
        check("enable", 32'h0, {31'h0, TRAINING_ENABLE});
        f.preset_req = 1'b1;
        frame(f);
        chk(1'b1);
        bus(1'b1, krts_pkg::ADDR_TAP_READ, 32'hFFFF_FFFF, 4'hF);
        chk(1'b1);
        bus(1'b1, krts_pkg::ADDR_COEF_EXCH,
            {8'hFF, ef.preset_req, ef.init_req, 6'h2D, 16'hFFFF}, 4'hF);
        ef.coef_req = 6'h2D;
        chk(1'b0);
        bus(1'b1, krts_pkg::ADDR_COEF_EXCH, 32'h0012_0000, 4'hB);
        chk(1'b0);
        bus(1'b1, krts_pkg::ADDR_TRAIN_CTRL, 32'h1, 4'hF);
        bus(1'b1, krts_pkg::ADDR_COEF_EXCH, 32'h0, 4'hF);
        chk(1'b0);
        frame(f);
        er = rpt(et, f);
        et = nxt(et, f);
        ef = f;
        chk(1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
